// >>> rtl/vpd_pkg.sv
package vpd_pkg;

  // Register word addresses on the plain register port.
  localparam logic [7:0] VPD_OFS_CTRL      = 8'h00;
  localparam logic [7:0] VPD_OFS_LIVE_THR  = 8'h04;
  localparam logic [7:0] VPD_OFS_DEAD_THR  = 8'h08;
  localparam logic [7:0] VPD_OFS_LIVE_TIME = 8'h0C;
  localparam logic [7:0] VPD_OFS_DEAD_TIME = 8'h10;
  localparam logic [7:0] VPD_OFS_HYST      = 8'h14;
  localparam logic [7:0] VPD_OFS_FLAGS     = 8'h18;
  localparam logic [7:0] VPD_OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] VPD_OFS_IRQ_MASK  = 8'h20;

  // Control register field positions.
  localparam int VPD_CTRL_ENABLE_BIT = 0;
  localparam int VPD_CTRL_VTYPE_BIT  = 1;
  localparam int VPD_CTRL_PSEL_LSB   = 2;
  localparam int VPD_CTRL_NREQ_LSB   = 5;

  // Reset values of the settings.
  localparam logic       VPD_RST_ENABLE    = 1'b1;
  localparam logic       VPD_RST_VTYPE     = 1'b1;  // One selects phase-to-phase.
  localparam logic [2:0] VPD_RST_PSEL      = 3'h4;
  localparam logic [1:0] VPD_RST_NREQ      = 2'h1;
  localparam logic [3:0] VPD_RST_LIVE_THR  = 4'h5;  // Tenths of nominal.
  localparam logic [3:0] VPD_RST_DEAD_THR  = 4'h2;  // Tenths of nominal.
  localparam logic [13:0] VPD_RST_LIVE_TIME = 14'h0064; // Milliseconds.
  localparam logic [13:0] VPD_RST_DEAD_TIME = 14'h0064; // Milliseconds.
  localparam logic [5:0] VPD_RST_HYST      = 6'h28;  // Tenths of a percent.

  // Scale divisors for threshold and hysteresis settings.
  localparam int VPD_THR_DIV  = 10;
  localparam int VPD_HYST_DIV = 1000;

  // Interrupt event bit positions.
  localparam int VPD_EV_LIVE_RISE = 0;
  localparam int VPD_EV_LIVE_FALL = 1;
  localparam int VPD_EV_DEAD_RISE = 2;
  localparam int VPD_EV_DEAD_FALL = 3;

  // Millisecond tick derived from the system clock period.
  localparam int VPD_CLK_PERIOD_NS = 10;
  localparam int VPD_TICK_TIME_NS  = 1000000;
  localparam int VPD_TICK_CYCLES   = VPD_TICK_TIME_NS / VPD_CLK_PERIOD_NS;

endpackage : vpd_pkg

// >>> rtl/vpd_voltage_presence.sv
// Functional notes
// - Supervise only selected phases; voltage type chosen by a setting.
// - Phase live flag sets after voltage stays above live threshold for live time.
// - Voltage leaving live level clears phase live flag and restarts its timer.
// - Phase dead flag sets after voltage stays below dead threshold for dead time.
// - Voltage leaving dead level clears phase dead flag and restarts its timer.
// - Relative hysteresis band; re-entering band alone never re-triggers start.
// - Block input clears every phase and general flag and all live and dead timers.
// - General live set when enough supervised phases are live.
// - General live clears in the same step its condition fails.
// - General dead set when enough supervised phases are dead.
// - General dead clears in the same step its condition fails.
// - Operation setting off produces no live or dead outputs.
// - Three voltage inputs, block input, six phase flags, two general flags.
// - Live and dead times in milliseconds, step one, default 100.
// - Live threshold in tenths of nominal, default 0.5.
// - Hysteresis in percent of threshold, default 4.0.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vpd_voltage_presence
  import vpd_pkg::*;
#(
  parameter int VW          = 16,
  parameter int VNOM        = 4096,
  parameter int TICK_CYCLES = VPD_TICK_CYCLES
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [VW-1:0] phase1_voltage_in,
  input  wire logic [VW-1:0] phase2_voltage_in,
  input  wire logic [VW-1:0] phase3_voltage_in,
  input  wire logic          sample_valid,
  input  wire logic          block_in,
  output logic               voltage_type_sel,
  output logic               phase1_live_flag,
  output logic               phase2_live_flag,
  output logic               phase3_live_flag,
  output logic               phase1_dead_flag,
  output logic               phase2_dead_flag,
  output logic               phase3_dead_flag,
  output logic               general_live_flag,
  output logic               general_dead_flag,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  output logic               irq
);

  // Scaled threshold in sample units from a setting in tenths of nominal.
  function automatic logic [VW:0] thr_scale(input logic [3:0] tenths);
    int prod;
    prod = int'(tenths) * VNOM / VPD_THR_DIV;
    return (VW+1)'(prod);
  endfunction : thr_scale

  // Hysteresis band width as a fraction of a threshold.
  function automatic logic [VW:0] band_of(input logic [VW:0] thr, input logic [5:0] hyst);
    int prod;
    prod = int'(thr) * int'(hyst) / VPD_HYST_DIV;
    return (VW+1)'(prod);
  endfunction : band_of

  // Number of phases set in a three-bit group.
  function automatic logic [1:0] count3(input logic [2:0] v);
    return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
  endfunction : count3

  logic        enable_q;
  logic        vtype_q;
  logic [2:0]  psel_q;
  logic [1:0]  nreq_q;
  logic [3:0]  live_thr_q;
  logic [3:0]  dead_thr_q;
  logic [13:0] live_time_q;
  logic [13:0] dead_time_q;
  logic [5:0]  hyst_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_mask_q;
  logic [31:0] reg_rdata_q;

  logic [16:0] tick_cnt_q;
  logic        tick;

  logic [2:0]  live_cond_q, live_cond_d, dead_cond_q, dead_cond_d;
  logic [2:0]  live_flag_q, live_flag_d, dead_flag_q, dead_flag_d;
  logic [13:0] live_tmr_q [3];
  logic [13:0] live_tmr_d [3];
  logic [13:0] dead_tmr_q [3];
  logic [13:0] dead_tmr_d [3];
  logic        gen_live_q, gen_live_d, gen_dead_q, gen_dead_d;

  wire logic [VW-1:0] volt [3];
  wire logic [VW:0]   live_hi;
  wire logic [VW:0]   live_lo;
  wire logic [VW:0]   dead_lo;
  wire logic [VW:0]   dead_hi;
  wire logic          run;
  wire logic [2:0]    active;
  wire logic          wr_ctrl, wr_stat, wr_mask;
  wire logic [3:0]    events;
  wire logic [1:0]    live_cnt, dead_cnt;

  // Decoded thresholds; the band is subtracted or added around each one.
  assign volt[0] = phase1_voltage_in;
  assign volt[1] = phase2_voltage_in;
  assign volt[2] = phase3_voltage_in;
  assign live_hi = thr_scale(live_thr_q);
  assign live_lo = live_hi - band_of(live_hi, hyst_q);
  assign dead_lo = thr_scale(dead_thr_q);
  assign dead_hi = dead_lo + band_of(dead_lo, hyst_q);
  assign run     = enable_q && !block_in;
  assign active  = run ? psel_q : 3'h0;
  assign voltage_type_sel = vtype_q;

  // Millisecond tick divider; timers only ever see this enable pulse.
  assign tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_q <= 17'h00000;
    else        tick_cnt_q <= tick ? 17'h00000 : tick_cnt_q + 17'h00001;
  end

  // Per-phase detectors. A condition starts only beyond its threshold and
  // ends once the signal has left the hysteresis band or the phase goes inactive, so chatter
  // inside the band neither restarts nor re-arms the timer.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      live_cond_d[i] = live_cond_q[i];
      dead_cond_d[i] = dead_cond_q[i];
      if (!active[i]) begin
        live_cond_d[i] = 1'b0;
        dead_cond_d[i] = 1'b0;
      end else if (sample_valid) begin
        if ({1'b0, volt[i]} > live_hi)      live_cond_d[i] = 1'b1;
        else if ({1'b0, volt[i]} < live_lo) live_cond_d[i] = 1'b0;
        if ({1'b0, volt[i]} < dead_lo)      dead_cond_d[i] = 1'b1;
        else if ({1'b0, volt[i]} > dead_hi) dead_cond_d[i] = 1'b0;
      end
      if (!live_cond_d[i])                                   live_tmr_d[i] = 14'h0000;
      else if (tick && live_tmr_q[i] < live_time_q)          live_tmr_d[i] = live_tmr_q[i] + 14'h0001;
      else                                                   live_tmr_d[i] = live_tmr_q[i];
      if (!dead_cond_d[i])                                   dead_tmr_d[i] = 14'h0000;
      else if (tick && dead_tmr_q[i] < dead_time_q)          dead_tmr_d[i] = dead_tmr_q[i] + 14'h0001;
      else                                                   dead_tmr_d[i] = dead_tmr_q[i];
      live_flag_d[i] = live_cond_d[i] && (live_tmr_d[i] >= live_time_q);
      dead_flag_d[i] = dead_cond_d[i] && (dead_tmr_d[i] >= dead_time_q);
    end
  end

  // Phase combination from the next flag values so a general flag falls
  // in the same cycle as the phase flag that breaks its condition.
  assign live_cnt   = count3(live_flag_d);
  assign dead_cnt   = count3(dead_flag_d);
  assign gen_live_d = run && (nreq_q != 2'h0) && (live_cnt >= nreq_q);
  assign gen_dead_d = run && (nreq_q != 2'h0) && (dead_cnt >= nreq_q);

  // Detector state registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_cond_q <= 3'h0;
      dead_cond_q <= 3'h0;
      live_flag_q <= 3'h0;
      dead_flag_q <= 3'h0;
      gen_live_q  <= 1'b0;
      gen_dead_q  <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        live_tmr_q[i] <= 14'h0000;
        dead_tmr_q[i] <= 14'h0000;
      end
    end else begin
      live_cond_q <= live_cond_d;
      dead_cond_q <= dead_cond_d;
      live_flag_q <= live_flag_d;
      dead_flag_q <= dead_flag_d;
      gen_live_q  <= gen_live_d;
      gen_dead_q  <= gen_dead_d;
      for (int i = 0; i < 3; i++) begin
        live_tmr_q[i] <= live_tmr_d[i];
        dead_tmr_q[i] <= dead_tmr_d[i];
      end
    end
  end

  // Flag outputs all come straight from flip-flops.
  assign phase1_live_flag  = live_flag_q[0];
  assign phase2_live_flag  = live_flag_q[1];
  assign phase3_live_flag  = live_flag_q[2];
  assign phase1_dead_flag  = dead_flag_q[0];
  assign phase2_dead_flag  = dead_flag_q[1];
  assign phase3_dead_flag  = dead_flag_q[2];
  assign general_live_flag = gen_live_q;
  assign general_dead_flag = gen_dead_q;

  // Register write decode and interrupt events from general flag edges.
  assign wr_ctrl = reg_wr && (reg_addr == VPD_OFS_CTRL);
  assign wr_stat = reg_wr && (reg_addr == VPD_OFS_IRQ_STAT);
  assign wr_mask = reg_wr && (reg_addr == VPD_OFS_IRQ_MASK);
  assign events[VPD_EV_LIVE_RISE] = gen_live_d && !gen_live_q;
  assign events[VPD_EV_LIVE_FALL] = !gen_live_d && gen_live_q;
  assign events[VPD_EV_DEAD_RISE] = gen_dead_d && !gen_dead_q;
  assign events[VPD_EV_DEAD_FALL] = !gen_dead_d && gen_dead_q;
  assign irq = |(irq_stat_q & irq_mask_q);

  // Settings registers; the setting limits are left to software.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q    <= VPD_RST_ENABLE;
      vtype_q     <= VPD_RST_VTYPE;
      psel_q      <= VPD_RST_PSEL;
      nreq_q      <= VPD_RST_NREQ;
      live_thr_q  <= VPD_RST_LIVE_THR;
      dead_thr_q  <= VPD_RST_DEAD_THR;
      live_time_q <= VPD_RST_LIVE_TIME;
      dead_time_q <= VPD_RST_DEAD_TIME;
      hyst_q      <= VPD_RST_HYST;
      irq_mask_q  <= 4'h0;
    end else if (reg_wr) begin
      if (wr_ctrl) begin
        enable_q <= reg_wdata[VPD_CTRL_ENABLE_BIT];
        vtype_q  <= reg_wdata[VPD_CTRL_VTYPE_BIT];
        psel_q   <= reg_wdata[VPD_CTRL_PSEL_LSB +: 3];
        nreq_q   <= reg_wdata[VPD_CTRL_NREQ_LSB +: 2];
      end
      if (reg_addr == VPD_OFS_LIVE_THR)  live_thr_q  <= reg_wdata[3:0];
      if (reg_addr == VPD_OFS_DEAD_THR)  dead_thr_q  <= reg_wdata[3:0];
      if (reg_addr == VPD_OFS_LIVE_TIME) live_time_q <= reg_wdata[13:0];
      if (reg_addr == VPD_OFS_DEAD_TIME) dead_time_q <= reg_wdata[13:0];
      if (reg_addr == VPD_OFS_HYST)      hyst_q      <= reg_wdata[5:0];
      if (wr_mask)                       irq_mask_q  <= reg_wdata[3:0];
    end
  end

  // Sticky status, write one to clear; a new event in the clearing cycle wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_stat_q <= 4'h0;
    else        irq_stat_q <= (irq_stat_q & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | events;
  end

  // Read data stand for exactly one cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      unique case (reg_addr)
        VPD_OFS_CTRL:      reg_rdata_q <= {25'h0, nreq_q, psel_q, vtype_q, enable_q};
        VPD_OFS_LIVE_THR:  reg_rdata_q <= {28'h0, live_thr_q};
        VPD_OFS_DEAD_THR:  reg_rdata_q <= {28'h0, dead_thr_q};
        VPD_OFS_LIVE_TIME: reg_rdata_q <= {18'h0, live_time_q};
        VPD_OFS_DEAD_TIME: reg_rdata_q <= {18'h0, dead_time_q};
        VPD_OFS_HYST:      reg_rdata_q <= {26'h0, hyst_q};
        VPD_OFS_FLAGS:     reg_rdata_q <= {24'h0, gen_dead_q, dead_flag_q, gen_live_q, live_flag_q};
        VPD_OFS_IRQ_STAT:  reg_rdata_q <= {28'h0, irq_stat_q};
        VPD_OFS_IRQ_MASK:  reg_rdata_q <= {28'h0, irq_mask_q};
        default:           reg_rdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_q;

  // Checks on the detector behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_blocked;
    block_in;
  endsequence
  sequence s_live0_rises;
    !live_flag_q[0] ##1 live_flag_q[0];
  endsequence

  property p_block_clears;
    s_blocked |=> (live_flag_q == 3'h0) && (dead_flag_q == 3'h0) && !gen_live_q && !gen_dead_q
      && (live_tmr_q[0] == 14'h0000) && (dead_tmr_q[2] == 14'h0000);
  endproperty
  a_block_clears: assert property (p_block_clears) else $error("Block left an output set");

  property p_off_silent;
    !enable_q |=> !gen_live_q && !gen_dead_q && (live_flag_q == 3'h0) && (dead_flag_q == 3'h0);
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("Output while operation off");

  property p_unselected;
    !psel_q[1] |=> !live_flag_q[1] && !dead_flag_q[1];
  endproperty
  a_unselected: assert property (p_unselected) else $error("Unselected phase flagged");

  property p_live_after_time;
    s_live0_rises |-> (live_tmr_q[0] == live_time_q) && live_cond_q[0];
  endproperty
  a_live_after_time: assert property (p_live_after_time) else $error("Live flag too early");

  property p_live_drop;
    sample_valid && ({1'b0, volt[0]} < live_lo) |=> !live_flag_q[0] && live_tmr_q[0] == 14'h0000;
  endproperty
  a_live_drop: assert property (p_live_drop) else $error("Live flag held below band");

  property p_dead_drop;
    sample_valid && ({1'b0, volt[0]} > dead_hi) |=> !dead_flag_q[0] && dead_tmr_q[0] == 14'h0000;
  endproperty
  a_dead_drop: assert property (p_dead_drop) else $error("Dead flag held above band");

  property p_no_rearm_in_band;
    !live_cond_q[0] && sample_valid && ({1'b0, volt[0]} <= live_hi) |=> !live_cond_q[0];
  endproperty
  a_no_rearm_in_band: assert property (p_no_rearm_in_band) else $error("Band re-armed");

  property p_dead_after_time;
    $rose(dead_flag_q[0]) |-> $past(dead_cond_d[0]) && dead_tmr_q[0] >= dead_time_q;
  endproperty
  a_dead_after_time: assert property (p_dead_after_time) else $error("Dead flag too early");

  // The general flags follow the setting of the cycle before, so a setting change lags by one; a count change does not.
  property p_gen_live;
    gen_live_q == ((count3(live_flag_q) >= $past(nreq_q))
      && $past(nreq_q) != 2'h0 && $past(run));
  endproperty
  a_gen_live: assert property (p_gen_live) else $error("General live mismatch");

  property p_gen_dead;
    gen_dead_q == ((count3(dead_flag_q) >= $past(nreq_q))
      && $past(nreq_q) != 2'h0 && $past(run));
  endproperty
  a_gen_dead: assert property (p_gen_dead) else $error("General dead mismatch");

  property p_irq_live;
    $rose(gen_live_q) |-> irq_stat_q[VPD_EV_LIVE_RISE]
      && (!irq_mask_q[VPD_EV_LIVE_RISE] || irq);
  endproperty
  a_irq_live: assert property (p_irq_live) else $error("Live event not latched");

endmodule : vpd_voltage_presence
`default_nettype wire

// >>> verification/vpd_front_end.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural measurement front end: it presents the three magnitudes as one sample.
module vpd_front_end #(
  parameter int GAP = 3
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] set_v1,
  input  wire logic [15:0] set_v2,
  input  wire logic [15:0] set_v3,
  output logic [15:0]      v1,
  output logic [15:0]      v2,
  output logic [15:0]      v3,
  output logic             valid
);
  logic [7:0] cnt_q;

  // One sample every GAP clocks; between samples the lines carry the inverse value,
  // so a detector that looks at them outside the strobe sees nonsense.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      valid <= 1'b0;
      v1    <= 16'h0000;
      v2    <= 16'h0000;
      v3    <= 16'h0000;
    end else begin
      cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
      valid <= (cnt_q == 8'h00);
      v1    <= (cnt_q == 8'h00) ? set_v1 : ~set_v1;
      v2    <= (cnt_q == 8'h00) ? set_v2 : ~set_v2;
      v3    <= (cnt_q == 8'h00) ? set_v3 : ~set_v3;
    end
  end
endmodule : vpd_front_end
`default_nettype wire

// >>> verification/voltage_presence_detector_test.sv
`timescale 1ns/1ps
`default_nettype none
module voltage_presence_detector_test
  import vpd_pkg::*;
();
  localparam int TK  = 4;             // Clocks per millisecond tick, kept short.
  localparam int TM  = 3;             // Live and dead time in ticks.
  localparam int LHI = 5 * 4096 / 10; // Live level at 0.5 of nominal.
  localparam int DLO = 2 * 4096 / 10; // Dead level at 0.2 of nominal.
  localparam logic [15:0] VHI = 16'(LHI + 100);
  localparam logic [15:0] VLO = 16'(DLO - 200);
  localparam logic [15:0] VMID = 16'((LHI + DLO) / 2);
  logic        clk, rst_n, blk, wr, rd, vsel, irq, sv;
  logic        l1, l2, l3, d1, d2, d3, gl, gd;
  logic [7:0]  addr;
  logic [31:0] wd, rdat;
  logic [15:0] s1, s2, s3, p1, p2, p3;
  logic [7:0]  fl;
  int          num_errors, num_checks;
  logic [7:0]  ra [9] = '{VPD_OFS_CTRL, VPD_OFS_LIVE_THR, VPD_OFS_DEAD_THR, VPD_OFS_LIVE_TIME,
                          VPD_OFS_DEAD_TIME, VPD_OFS_HYST, VPD_OFS_IRQ_MASK, 8'h24, VPD_OFS_FLAGS};
  logic [31:0] rv [9] = '{32'h33, 32'h5, 32'h2, 32'h64, 32'h64, 32'h28, 32'h0, 32'h0, 32'h0};

  // Same layout as the flag register, so one mask serves both views.
  assign fl = {gd, d3, d2, d1, gl, l3, l2, l1};

  vpd_front_end #(.GAP(3)) fe (.clk(clk), .rst_n(rst_n), .set_v1(s1), .set_v2(s2),
    .set_v3(s3), .v1(p1), .v2(p2), .v3(p3), .valid(sv));

  vpd_voltage_presence #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst_n(rst_n),
    .phase1_voltage_in(p1), .phase2_voltage_in(p2), .phase3_voltage_in(p3),
    .sample_valid(sv), .block_in(blk), .voltage_type_sel(vsel),
    .phase1_live_flag(l1), .phase2_live_flag(l2), .phase3_live_flag(l3),
    .phase1_dead_flag(d1), .phase2_dead_flag(d2), .phase3_dead_flag(d3),
    .general_live_flag(gl), .general_dead_flag(gd), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .irq(irq));

  function automatic logic [31:0] ctl(input int en, input int vt, input logic [2:0] ps,
                                      input logic [1:0] nq);
    return {25'h0, nq, ps, 1'(vt), 1'(en)};
  endfunction : ctl

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr   <= 1'b1;
    addr <= a;
    wd   <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, exp);
  endtask : rchk

  task automatic setv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    @(posedge clk);
    s1 <= a;
    s2 <= b;
    s3 <= c;
  endtask : setv

  task automatic hold(input int n, input logic [7:0] m, input logic [7:0] v);
    repeat (n) @(posedge clk);
    #1 chk({24'h0, fl & m}, {24'h0, v});
  endtask : hold

  // Bounded wait for a flag pattern; a pattern that never comes is a mismatch.
  task automatic waitfl(input logic [7:0] m, input logic [7:0] v, input int n);
    int i;
    @(posedge clk);
    #1;
    for (i = 0; i < n && (fl & m) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk({24'h0, fl & m}, {24'h0, v});
  endtask : waitfl

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole sequence needs well under two thousand clocks.
  initial begin
    #200000;
    num_errors++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    {blk, wr, rd, addr, wd} = '0;
    {s1, s2, s3} = {VMID, VMID, VMID};
    num_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk({31'h0, vsel}, 32'h1);
    wreg(8'h24, 32'hFF);
    wreg(VPD_OFS_FLAGS, 32'hFF);
    for (int i = 0; i < 9; i++) rchk(ra[i], rv[i]);
    $display("test reset done");
    wreg(VPD_OFS_LIVE_TIME, TM);
    wreg(VPD_OFS_DEAD_TIME, TM);
    wreg(VPD_OFS_IRQ_MASK, 32'hF);
    wreg(VPD_OFS_CTRL, ctl(1, 1, 3'h7, 2'h1));
    setv(VHI, VHI, VHI);
    hold(TK * (TM - 1) - 1, 8'h0F, 8'h00);
    waitfl(8'h0F, 8'h0F, 20);
    chk({31'h0, irq}, 32'h1);
    setv(16'(LHI - 40), VHI, VHI);
    hold(20, 8'h0F, 8'h0F);
    setv(16'(LHI - 120), VHI, VHI);
    waitfl(8'h0F, 8'h0E, 6);
    setv(16'(LHI - 40), VHI, VHI);
    hold(20, 8'h0F, 8'h0E);
    setv(VHI, VHI, VHI);
    hold(TK * (TM - 1) - 1, 8'h0F, 8'h0E);
    waitfl(8'h0F, 8'h0F, 20);
    $display("test live done");
    wreg(VPD_OFS_CTRL, ctl(1, 1, 3'h7, 2'h3));
    setv(VHI, 16'(LHI - 120), VHI);
    waitfl(8'h02, 8'h00, 8);
    chk({31'h0, gl}, 32'h0);
    wreg(VPD_OFS_CTRL, ctl(1, 1, 3'h7, 2'h2));
    hold(2, 8'h08, 8'h08);
    wreg(VPD_OFS_CTRL, ctl(1, 1, 3'h7, 2'h3));
    hold(2, 8'h08, 8'h00);
    rchk(VPD_OFS_IRQ_STAT, 32'h3);
    wreg(VPD_OFS_IRQ_STAT, 32'h1);
    rchk(VPD_OFS_IRQ_STAT, 32'h2);
    wreg(VPD_OFS_IRQ_STAT, 32'h2);
    #1 chk({31'h0, irq}, 32'h0);
    $display("test count done");
    wreg(VPD_OFS_IRQ_MASK, 32'h0);
    wreg(VPD_OFS_CTRL, ctl(1, 1, 3'h7, 2'h1));
    setv(VLO, VLO, VLO);
    hold(TK * (TM - 1) - 1, 8'hF0, 8'h00);
    waitfl(8'hFF, 8'hF0, 20);
    setv(16'(DLO + 20), VLO, VLO);
    hold(20, 8'hF0, 8'hF0);
    setv(16'(DLO + 60), VLO, VLO);
    waitfl(8'hF0, 8'hE0, 6);
    rchk(VPD_OFS_IRQ_STAT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wreg(VPD_OFS_IRQ_STAT, 32'h7);
    wreg(VPD_OFS_CTRL, ctl(1, 1, 3'h7, 2'h3));
    hold(2, 8'h80, 8'h00);
    $display("test dead done");
    setv(VLO, VLO, VLO);
    waitfl(8'hF0, 8'hF0, 20);
    @(posedge clk);
    blk <= 1'b1;
    hold(2, 8'hFF, 8'h00);
    hold(20, 8'hFF, 8'h00);
    @(posedge clk);
    blk <= 1'b0;
    hold(TK * (TM - 1) - 1, 8'hF0, 8'h00);
    waitfl(8'hF0, 8'hF0, 20);
    wreg(VPD_OFS_CTRL, ctl(0, 1, 3'h7, 2'h3));
    hold(2, 8'hFF, 8'h00);
    hold(20, 8'hFF, 8'h00);
    $display("test block done");
    wreg(VPD_OFS_CTRL, ctl(1, 0, 3'h2, 2'h1));
    waitfl(8'hFF, 8'hA0, 20);
    rchk(VPD_OFS_FLAGS, 32'hA0);
    chk({31'h0, vsel}, 32'h0);
    $display("test select done");
    conclude();
  end
endmodule : voltage_presence_detector_test
`default_nettype wire
